// ### avsp_top.sv
// AV stream packetizer: codec port, transmit framer, receive unpacker, APB registers.
// Assumes pclk is the link system clock and av_port_clock is the codec's free clock.
`default_nettype none
module avsp_top
   import avsp_pkg::*;
#(
   parameter int CYC_CLKS = avsp_pkg::CYCLE_CLKS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic av_port_clock,
   input wire logic av_byte_valid,
   input wire logic av_packet_start,
   input wire logic [7:0] av_port_bytes,
   input wire logic av_frame_sync_in,
   output logic av_frame_sync_out,
   output logic [31:0] iso_tx_data,
   output logic iso_tx_valid,
   output logic iso_tx_last,
   input wire logic iso_tx_ready,
   input wire logic [31:0] iso_rx_data,
   input wire logic iso_rx_valid,
   input wire logic iso_rx_first,
   input wire logic iso_rx_last
);
   import avsp_pkg::*;

   typedef struct packed {
      avsp_av_st_t st;
      logic [1:0] bcnt;
      logic [23:0] acc;
      logic [9:0] qcnt;
      logic [10:0] wr_ptr;
      logic [10:0] base;
      logic [10:0] cgray;
      logic start_tgl;
      logic err_tgl;
      logic commit_tgl;
      logic [10:0] rgray_s1;
      logic [10:0] rgray_s2;
      logic [9:0] len_s1;
      logic [9:0] len_s2;
   } avsp_av_t;

   typedef struct packed {
      logic tx_en;
      logic ts_en;
      logic rx_en;
      logic [2:0] syt_off;
      logic [9:0] pkt_len;
      logic [31:0] cip0;
      logic [31:0] cip1;
      logic [31:0] rxcip0;
      logic [31:0] rxcip1;
      logic in_err;
      logic [12:0] cyc_off;
      logic [12:0] cyc_cnt;
      logic [15:0] stamp;
      logic [15:0] syt_tx;
      logic [15:0] rx_syt;
      logic rx_syt_pend;
      logic [2:0] start_sy;
      logic [2:0] err_sy;
      logic [2:0] fs_sy;
      logic [2:0] commit_sy;
      logic [10:0] wgray_s1;
      logic [10:0] wgray_s2;
      avsp_tx_st_t tx_st;
      logic [10:0] rd_ptr;
      logic [10:0] rgray;
      logic [9:0] qleft;
      logic [31:0] tx_data;
      logic tx_valid;
      logic tx_last;
      logic [10:0] rx_wr;
      logic [10:0] rx_rd;
      logic [1:0] rx_qidx;
      logic rx_dv;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic fs_out;
   } avsp_sys_t;

   avsp_av_t a_r;
   avsp_av_t a_nxt;
   avsp_sys_t s_r;
   avsp_sys_t s_nxt;

   logic [31:0] tx_mem [BUF_DEPTH];
   logic [31:0] rx_mem [BUF_DEPTH];
   logic tx_we;
   logic [9:0] tx_wa;
   logic [31:0] tx_wd;
   logic rx_we;
   logic [9:0] rx_wa;
   logic [31:0] rx_wd;

   // Codec side, on the codec's own clock
   always_comb
   begin
      logic [10:0] rbin;
      logic full;
      rbin = avsp_gray2bin(a_r.rgray_s2);
      full = (a_r.wr_ptr - rbin) == BUF_FULL;
      a_nxt = a_r;
      tx_we = 1'b0;
      tx_wa = a_r.wr_ptr[9:0];
      tx_wd = {a_r.acc, av_port_bytes};
      a_nxt.rgray_s1 = s_r.rgray;
      a_nxt.rgray_s2 = a_r.rgray_s1;
      a_nxt.len_s1 = s_r.pkt_len;
      a_nxt.len_s2 = a_r.len_s1;
      if (av_byte_valid && av_packet_start)
      begin
         if (a_r.st == AV_COLLECT)
            a_nxt.err_tgl = ~a_r.err_tgl;
         // Rewinding to the committed base throws the partial packet away
         a_nxt.wr_ptr = a_r.base;
         a_nxt.acc = {16'h0000, av_port_bytes};
         a_nxt.bcnt = 2'h1;
         a_nxt.qcnt = 10'h000;
         a_nxt.st = AV_COLLECT;
         a_nxt.start_tgl = ~a_r.start_tgl;
      end
      else if (av_byte_valid && a_r.st == AV_COLLECT)
      begin
         a_nxt.bcnt = a_r.bcnt + 2'h1;
         a_nxt.acc = {a_r.acc[15:0], av_port_bytes};
         if (a_r.bcnt == 2'h3)
         begin
            if (full)
            begin
               // No room: the packet is dropped rather than stalling the codec
               a_nxt.st = AV_IDLE;
               a_nxt.wr_ptr = a_r.base;
            end
            else
            begin
               tx_we = 1'b1;
               a_nxt.wr_ptr = a_r.wr_ptr + 11'h001;
               a_nxt.qcnt = a_r.qcnt + 10'h001;
               if (a_r.qcnt + 10'h001 == a_r.len_s2)
               begin
                  a_nxt.base = a_r.wr_ptr + 11'h001;
                  a_nxt.cgray = avsp_bin2gray(a_r.wr_ptr + 11'h001);
                  a_nxt.commit_tgl = ~a_r.commit_tgl;
                  a_nxt.st = AV_IDLE;
               end
            end
         end
      end
   end

   // Reset release is not resynchronised; the codec clock may be stopped during reset
   always_ff @(posedge av_port_clock or negedge presetn)
   begin
      if (!presetn)
      begin
         a_r <= '0;
         a_r.len_s1 <= PKTLEN_RST;
         a_r.len_s2 <= PKTLEN_RST;
      end
      else
         a_r <= a_nxt;
   end

   always_ff @(posedge av_port_clock)
   begin
      if (tx_we)
         tx_mem[tx_wa] <= tx_wd;
   end

   // Link side, cycle timer and registers on the system clock
   always_comb
   begin
      logic [15:0] cur_syt;
      logic dv_tx;
      logic [10:0] wbin;
      logic pkt_ready;
      logic rx_empty;
      logic load;
      logic [1:0] idx;
      logic setup;
      logic access;
      cur_syt = {s_r.cyc_cnt[3:0], s_r.cyc_off[12:1]};
      dv_tx = s_r.cip1[FMT_LSB +: 6] == FMT_DV;
      wbin = avsp_gray2bin(s_r.wgray_s2);
      pkt_ready = (wbin - s_r.rd_ptr) >= {1'b0, s_r.pkt_len};
      rx_empty = s_r.rx_wr == s_r.rx_rd;
      load = ~s_r.tx_valid | iso_tx_ready;
      idx = iso_rx_first ? 2'h0 : s_r.rx_qidx;
      setup = psel & ~penable;
      access = psel & penable & s_r.pready;
      s_nxt = s_r;
      rx_we = 1'b0;
      rx_wa = s_r.rx_wr[9:0];
      rx_wd = iso_rx_data;

      // Cycle timer, 125 us per cycle
      if (s_r.cyc_off == 13'(CYC_CLKS - 1))
      begin
         s_nxt.cyc_off = 13'h0000;
         s_nxt.cyc_cnt = s_r.cyc_cnt + 13'h0001;
      end
      else
         s_nxt.cyc_off = s_r.cyc_off + 13'h0001;

      // Synchronisers; the committed pointer jumps a packet, so it is taken once its toggle has settled
      s_nxt.start_sy = {s_r.start_sy[1:0], a_r.start_tgl};
      s_nxt.err_sy = {s_r.err_sy[1:0], a_r.err_tgl};
      s_nxt.fs_sy = {s_r.fs_sy[1:0], av_frame_sync_in};
      s_nxt.commit_sy = {s_r.commit_sy[1:0], a_r.commit_tgl};
      s_nxt.wgray_s1 = a_r.cgray;
      if (s_r.commit_sy[1] ^ s_r.commit_sy[2])
         s_nxt.wgray_s2 = s_r.wgray_s1;

      if (s_r.start_sy[1] ^ s_r.start_sy[2])
         s_nxt.stamp = cur_syt;
      if (dv_tx && s_r.fs_sy[1] && !s_r.fs_sy[2])
         s_nxt.syt_tx = {s_r.cyc_cnt[3:0] + 4'(s_r.syt_off), s_r.cyc_off[12:1]};

      // Transmit framer
      if (load)
      begin
         unique case (s_r.tx_st)
            TX_IDLE:
            begin
               s_nxt.tx_valid = 1'b0;
               s_nxt.tx_last = 1'b0;
               if (s_r.tx_en && pkt_ready && !s_r.tx_valid)
               begin
                  s_nxt.tx_data = s_r.cip0;
                  s_nxt.tx_valid = 1'b1;
                  s_nxt.tx_st = TX_CIP1;
               end
            end
            TX_CIP1:
            begin
               s_nxt.tx_data = {s_r.cip1[31:16], dv_tx ? s_r.syt_tx : SYT_NONE};
               s_nxt.syt_tx = SYT_NONE;
               s_nxt.qleft = s_r.pkt_len;
               s_nxt.tx_st = (s_r.ts_en && !dv_tx) ? TX_SPH : TX_DATA;
            end
            TX_SPH:
            begin
               s_nxt.tx_data = {16'h0000, s_r.stamp};
               s_nxt.tx_st = TX_DATA;
            end
            TX_DATA:
            begin
               s_nxt.tx_data = tx_mem[s_r.rd_ptr[9:0]];
               s_nxt.rd_ptr = s_r.rd_ptr + 11'h001;
               s_nxt.qleft = s_r.qleft - 10'h001;
               s_nxt.tx_last = s_r.qleft == 10'h001;
               if (s_r.qleft == 10'h001)
                  s_nxt.tx_st = TX_IDLE;
            end
         endcase
      end
      s_nxt.rgray = avsp_bin2gray(s_nxt.rd_ptr);

      // Receive unpacker
      if (s_r.rx_en && iso_rx_valid)
      begin
         s_nxt.rx_qidx = (idx == 2'h3) ? 2'h3 : idx + 2'h1;
         if (iso_rx_last)
            s_nxt.rx_qidx = 2'h0;
         if (idx == 2'h0)
            s_nxt.rxcip0 = iso_rx_data;
         else if (idx == 2'h1)
         begin
            s_nxt.rxcip1 = iso_rx_data;
            s_nxt.rx_dv = iso_rx_data[FMT_LSB +: 6] == FMT_DV;
            if (iso_rx_data[FMT_LSB +: 6] == FMT_DV && iso_rx_data[15:0] != SYT_NONE)
            begin
               s_nxt.rx_syt = iso_rx_data[15:0];
               s_nxt.rx_syt_pend = 1'b1;
            end
         end
         // Non-DV streams carry a source packet header at quadlet 2, which is skipped
         else if ((idx == 2'h3 || s_r.rx_dv) && (s_r.rx_wr - s_r.rx_rd) != BUF_FULL)
         begin
            rx_we = 1'b1;
            s_nxt.rx_wr = s_r.rx_wr + 11'h001;
         end
      end

      // Frame sync output follows the cycle timer, not the codec clock
      s_nxt.fs_out = 1'b0;
      if (s_r.rx_syt_pend && cur_syt == s_r.rx_syt && !s_r.cyc_off[0])
      begin
         s_nxt.fs_out = 1'b1;
         s_nxt.rx_syt_pend = 1'b0;
      end

      // APB slave: one wait-free access phase
      s_nxt.pready = setup;
      s_nxt.pslverr = 1'b0;
      if (setup)
      begin
         unique case (paddr)
            ADDR_CTRL:
               s_nxt.prdata = {25'h0, s_r.syt_off, 1'b0, s_r.rx_en, s_r.ts_en, s_r.tx_en};
            ADDR_PKTLEN:
               s_nxt.prdata = {22'h0, s_r.pkt_len};
            ADDR_TXCIP0:
               s_nxt.prdata = s_r.cip0;
            ADDR_TXCIP1:
               s_nxt.prdata = s_r.cip1;
            ADDR_STATUS:
               s_nxt.prdata = {28'h0, s_r.in_err, 1'b0, ~rx_empty, pkt_ready};
            ADDR_RXCIP0:
               s_nxt.prdata = s_r.rxcip0;
            ADDR_RXCIP1:
               s_nxt.prdata = s_r.rxcip1;
            ADDR_RXDATA:
               s_nxt.prdata = rx_empty ? 32'h00000000 : rx_mem[s_r.rx_rd[9:0]];
            ADDR_CYCTIME:
               s_nxt.prdata = {6'h00, s_r.cyc_cnt, s_r.cyc_off};
            default:
            begin
               s_nxt.prdata = 32'h00000000;
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end
      if (access && !s_r.pslverr && pwrite)
      begin
         unique case (paddr)
            ADDR_CTRL:
            begin
               s_nxt.tx_en = pwdata[CTRL_TX_EN];
               s_nxt.ts_en = pwdata[CTRL_TS_EN];
               s_nxt.rx_en = pwdata[CTRL_RX_EN];
               if (pwdata[CTRL_SYTOFF +: 3] >= SYTOFF_MIN && pwdata[CTRL_SYTOFF +: 3] <= SYTOFF_MAX)
                  s_nxt.syt_off = pwdata[CTRL_SYTOFF +: 3];
            end
            ADDR_PKTLEN:
               if (pwdata[9:0] != 10'h000)
                  s_nxt.pkt_len = pwdata[9:0];
            ADDR_TXCIP0:
               s_nxt.cip0 = pwdata;
            ADDR_TXCIP1:
               s_nxt.cip1 = pwdata;
            ADDR_STATUS:
               if (pwdata[STAT_INERR])
                  s_nxt.in_err = 1'b0;
            default:
               s_nxt.tx_en = s_nxt.tx_en;
         endcase
      end
      if (access && !pwrite && paddr == ADDR_RXDATA && !rx_empty)
         s_nxt.rx_rd = s_r.rx_rd + 11'h001;
      // A new error in the clearing cycle still lands
      if (s_r.err_sy[1] ^ s_r.err_sy[2])
         s_nxt.in_err = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
         s_r.syt_off <= SYTOFF_RST;
         s_r.pkt_len <= PKTLEN_RST;
         s_r.syt_tx <= SYT_NONE;
      end
      else
         s_r <= s_nxt;
   end

   always_ff @(posedge pclk)
   begin
      if (rx_we)
         rx_mem[rx_wa] <= rx_wd;
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign av_frame_sync_out = s_r.fs_out;
   assign iso_tx_data = s_r.tx_data;
   assign iso_tx_valid = s_r.tx_valid;
   assign iso_tx_last = s_r.tx_last;
endmodule
`default_nettype wire

// ### avsp_pkg.sv
// Constants, types and helpers for the AV stream packetizer.
// Assumes an APB master on pclk and a byte-wide codec on its own port clock.
// How it works
// - Byte-wide codec input with own clock, strobes
// - No data until valid and start both high
// - Stamp captured at start, sent in header
// - DV streams get no per-packet source stamps
// - Early restart discards packet, sets error bit3
// - Complete packet framed with CIP header, configured size
// - DV frame sync stamped into SYT, offset ahead
// - Software picks SYT offset of 2-4 cycles
// - Received DV SYT matching cycle timer pulses frame sync
// - Frame sync timed from cycle timer only
// - Received CIP header selects payload unpacking
// - Received CIP headers readable by software
// - 1024-quadlet transmit and receive buffers
// - Transmit and receive run concurrently, unattended
// - Link side and cycle timer on system clock
`default_nettype none
package avsp_pkg;
   localparam int CLK_NS = 20;
   localparam int CYCLE_US = 125;
   localparam int CYCLE_CLKS = (CYCLE_US * 1000) / CLK_NS;
   localparam int BUF_DEPTH = 1024;
   localparam int PTR_W = 11;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_PKTLEN = 12'h004;
   localparam logic [11:0] ADDR_TXCIP0 = 12'h008;
   localparam logic [11:0] ADDR_TXCIP1 = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h02C;
   localparam logic [11:0] ADDR_RXCIP0 = 12'h030;
   localparam logic [11:0] ADDR_RXCIP1 = 12'h034;
   localparam logic [11:0] ADDR_RXDATA = 12'h038;
   localparam logic [11:0] ADDR_CYCTIME = 12'h03C;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_TS_EN = 1;
   localparam int CTRL_RX_EN = 2;
   localparam int CTRL_SYTOFF = 4;
   localparam int STAT_TXPEND = 0;
   localparam int STAT_RXAVAIL = 1;
   localparam int STAT_INERR = 3;
   localparam int FMT_LSB = 24;
   localparam logic [5:0] FMT_DV = 6'h00;
   localparam logic [2:0] SYTOFF_MIN = 3'h2;
   localparam logic [2:0] SYTOFF_MAX = 3'h4;
   localparam logic [2:0] SYTOFF_RST = 3'h3;
   localparam logic [9:0] PKTLEN_RST = 10'h008;
   localparam logic [15:0] SYT_NONE = 16'hFFFF;
   localparam logic [10:0] BUF_FULL = 11'h400;

   typedef enum logic [0:0] {AV_IDLE, AV_COLLECT} avsp_av_st_t;
   typedef enum logic [1:0] {TX_IDLE, TX_CIP1, TX_SPH, TX_DATA} avsp_tx_st_t;

   function automatic logic [10:0] avsp_bin2gray(input logic [10:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [10:0] avsp_gray2bin(input logic [10:0] g);
      logic [10:0] b;
      b[10] = g[10];
      for (int i = 9; i >= 0; i--)
         b[i] = b[i + 1] ^ g[i];
      return b;
   endfunction
endpackage
`default_nettype wire

// ### avsp_codec.sv
// Codec model: sends byte-wide packets on the AV port clock.
// Assumes one caller at a time; the clock comes from the bench.
`default_nettype none
module avsp_codec (
   input wire logic clk,
   output logic valid,
   output logic start,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      valid = 1'b0;
      start = 1'b0;
      data = 8'h00;
   end
   // Idle data shows the inverse of the last byte, never a stale copy
   task automatic send(input int n, input logic [7:0] b, input bit sop);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         valid <= 1'b1;
         start <= sop && i == 0;
         data <= b + 8'(i);
      end
      @(posedge clk);
      valid <= 1'b0;
      start <= 1'b0;
      data <= ~data;
   endtask
endmodule
`default_nettype wire

// ### avsp_chk.sv
// Checker: register bus and link stream timing at the top ports.
// Assumes every watched port lives in the pclk domain.
`default_nettype none
module avsp_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] iso_tx_data,
   input wire logic iso_tx_valid,
   input wire logic iso_tx_last,
   input wire logic iso_tx_ready,
   input wire logic av_frame_sync_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence last_take_s;
      iso_tx_valid && iso_tx_ready && iso_tx_last;
   endsequence
   a_ready_after_setup: assert property (setup_s |=> pready) else $error("no ready");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
   a_ready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
   a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
   a_tx_word_hold: assert property (iso_tx_valid && !iso_tx_ready |=> iso_tx_valid && $stable(iso_tx_data)
      && $stable(iso_tx_last)) else $error("word dropped");
   a_tx_last_valid: assert property (iso_tx_last |-> iso_tx_valid) else $error("stray last");
   a_tx_gap_after: assert property (last_take_s |=> !iso_tx_valid) else $error("no gap");
   a_sync_one_pulse: assert property (av_frame_sync_out |=> !av_frame_sync_out) else $error("long sync");
endmodule
bind avsp_top avsp_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .iso_tx_data(iso_tx_data), .iso_tx_valid(iso_tx_valid),
   .iso_tx_last(iso_tx_last), .iso_tx_ready(iso_tx_ready), .av_frame_sync_out(av_frame_sync_out));
`default_nettype wire

// ### avsp_bench.sv
// Bench: APB tasks, codec model and link stubs around the packetizer.
// Assumes the checker binds itself to the top module.
`default_nettype none
module avsp_bench;
   import avsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, avclk, vld, sop, fs_in, fs_out;
   logic tx_v, tx_l, tx_r, rx_v, rx_f, rx_l;
   logic [7:0] bytes;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, tx_d, rx_d, q, c1;
   logic [3:0] d4;
   int error_cnt, cmp_count;
   int offs[5] = '{2, 5, 4, 1, 3};
   int keep[5] = '{2, 2, 4, 4, 3};
   localparam int CYC = 64;
   int t, wait_n;
   logic [15:0] syt;
   avsp_top #(.CYC_CLKS(CYC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .av_port_clock(avclk), .av_byte_valid(vld), .av_packet_start(sop), .av_port_bytes(bytes),
      .av_frame_sync_in(fs_in), .av_frame_sync_out(fs_out), .iso_tx_data(tx_d), .iso_tx_valid(tx_v),
      .iso_tx_last(tx_l), .iso_tx_ready(tx_r), .iso_rx_data(rx_d), .iso_rx_valid(rx_v),
      .iso_rx_first(rx_f), .iso_rx_last(rx_l));
   avsp_codec codec_u (.clk(avclk), .valid(vld), .start(sop), .data(bytes));
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial
   begin
      avclk = 1'b0;
      #7;
      forever #16 avclk = ~avclk;
   end
   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic hang;
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         hang();
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Ready drops between words so every word after the first of a packet is held once
   task automatic pop(output logic [31:0] d, output logic l);
      int n;
      n = 0;
      tx_r <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (tx_v !== 1'b1 && n < 400);
      if (n >= 400)
         hang();
      d = tx_d;
      l = tx_l;
      tx_r <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tx_check(input logic [15:0] hi, input bit sph, input logic [7:0] b);
      logic [31:0] d;
      logic l;
      pop(d, l);
      chk(d, 32'h01234567);
      pop(c1, l);
      chk({16'h0, c1[31:16]}, {16'h0, hi});
      if (sph)
      begin
         pop(d, l);
         chk({16'h0, d[31:16]}, 32'h0);
         chk(32'(d[15:0] != SYT_NONE), 32'h1);
         t = (int'(d[15:12]) * CYC + int'(d[11:0]) * 2 - int'(q[16:13]) * CYC - int'(q[12:0])) & (16 * CYC - 1);
         chk(32'(t < CYC), 32'h1);
      end
      for (int i = 0; i < 2; i++)
      begin
         pop(d, l);
         chk(d, {b + 8'(4 * i), b + 8'(4 * i + 1), b + 8'(4 * i + 2), b + 8'(4 * i + 3)});
         chk(32'(l), 32'(i));
      end
   endtask
   task automatic rx_word(input logic [31:0] d, input logic f, input logic l);
      rx_v <= 1'b1;
      rx_f <= f;
      rx_l <= l;
      rx_d <= d;
      @(posedge pclk);
   endtask
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, tx_r, rx_v, rx_f, rx_l, rx_d, fs_in} = '0;
      error_cnt = 0;
      cmp_count = 0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge avclk);
      @(posedge pclk);
      rd(ADDR_CTRL);
      chk(q, 32'h30);
      rd(ADDR_PKTLEN);
      chk(q, 32'h8);
      rd(ADDR_STATUS);
      chk(q, 32'h0);
      rd(12'h100);
      chk(q, 32'h0);
      chk(32'(err), 32'h1);
      foreach (offs[i])
      begin
         wr(ADDR_CTRL, 32'(offs[i]) << 4);
         rd(ADDR_CTRL);
         chk(q, 32'(keep[i]) << 4);
      end
      wr(ADDR_PKTLEN, 32'h2);
      wr(ADDR_TXCIP0, 32'h01234567);
      wr(ADDR_TXCIP1, 32'h605A0000);
      wr(ADDR_CTRL, 32'h37);
      rd(ADDR_CYCTIME);
      codec_u.send(3, 8'hE0, 1'b0);
      codec_u.send(8, 8'h10, 1'b1);
      @(posedge pclk);
      tx_check(16'h605A, 1'b1, 8'h10);
      codec_u.send(4, 8'h30, 1'b1);
      rd(ADDR_CYCTIME);
      codec_u.send(8, 8'h40, 1'b1);
      @(posedge pclk);
      tx_check(16'h605A, 1'b1, 8'h40);
      rd(ADDR_STATUS);
      chk(q & 32'h8, 32'h8);
      wr(ADDR_STATUS, 32'h8);
      rd(ADDR_STATUS);
      chk(q & 32'h8, 32'h0);
      wr(ADDR_TXCIP1, 32'h405A0000);
      wr(ADDR_CTRL, 32'h47);
      rd(ADDR_CYCTIME);
      fs_in <= 1'b1;
      repeat (4) @(posedge pclk);
      fs_in <= 1'b0;
      codec_u.send(8, 8'h50, 1'b1);
      @(posedge pclk);
      tx_check(16'h405A, 1'b0, 8'h50);
      d4 = c1[15:12] - q[16:13];
      chk(32'(d4 == 4'h4 || d4 == 4'h5), 32'h1);
      rx_word(32'h11223344, 1'b1, 1'b0);
      rx_word(32'h20FFFFFF, 1'b0, 1'b0);
      rx_word(32'hAAAA0001, 1'b0, 1'b0);
      rx_word(32'hCAFE0002, 1'b0, 1'b1);
      rx_v <= 1'b0;
      rx_l <= 1'b0;
      rx_d <= 32'h3501FFFD;
      @(posedge pclk);
      rd(ADDR_RXCIP0);
      chk(q, 32'h11223344);
      rd(ADDR_RXCIP1);
      chk(q, 32'h20FFFFFF);
      rd(ADDR_RXDATA);
      chk(q, 32'hCAFE0002);
      rd(ADDR_STATUS);
      chk(q & 32'h2, 32'h0);
      rd(ADDR_CYCTIME);
      syt = {q[16:13] + 4'h2, 12'h005};
      rx_word(32'h01020304, 1'b1, 1'b0);
      rx_word({16'h8000, syt}, 1'b0, 1'b0);
      rx_word(32'h5A5A0003, 1'b0, 1'b1);
      rx_v <= 1'b0;
      rx_l <= 1'b0;
      wait_n = 0;
      do
      begin
         @(posedge pclk);
         wait_n++;
      end
      while (fs_out !== 1'b1 && wait_n < 400);
      if (wait_n >= 400)
         hang();
      rd(ADDR_CYCTIME);
      chk(32'(q[16:13] == syt[15:12] && q[12:0] >= 13'h00A && q[12:0] < 13'h010), 32'h1);
      rd(ADDR_RXCIP1);
      chk(q, {16'h8000, syt});
      rd(ADDR_RXDATA);
      chk(q, 32'h5A5A0003);
      conclude();
   end
endmodule
`default_nettype wire
